// ==== rtl/rwm_pkg.sv ====
package rwm_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          POR_DELAY_CYC   = 4064;
  localparam int          PIN_DRIVE_CYC   = 4;
  localparam int          PIN_SAMPLE_CYC  = 2;
  localparam int          RATE_WINDOW_CYC = 64;
  // clock monitor trip time: a bus clock tick gap longer than this is a failure
  localparam int          CM_TIMEOUT_NS   = 20000;
  localparam int          CM_TIMEOUT_CYC  = CM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int          WDOG_DIV_LOG2   = 15;
  localparam int          SEQ_CNT_W       = 12;

  // --------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [7:0]  OFS_OPTIONS     = 8'h00;
  localparam logic [7:0]  OFS_SERVICE     = 8'h04;
  localparam logic [7:0]  OFS_TEST        = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0c;

  // --------------------------------------------------------------------
  // field values
  // --------------------------------------------------------------------
  localparam logic [7:0]  SERVICE_ARM     = 8'h55;
  localparam logic [7:0]  SERVICE_CLEAR   = 8'haa;
  localparam int          TEST_RESET_DISABLE_BIT = 0;

  // system_options layout, bit 7 down to bit 0; bit 2 is unimplemented
  typedef struct packed {
    logic       adpu;
    logic       csel;
    logic       irqEdgeSelect;
    logic       dly;
    logic       clockMonitorEnable;
    logic       unused;
    logic [1:0] watchdogRate;
  } rwm_options_t;

  localparam rwm_options_t OPTIONS_RESET  = 8'h10;

  typedef enum logic [1:0] {
    CAUSE_POWER_PIN,
    CAUSE_CLOCK_MON,
    CAUSE_WATCHDOG
  } rwm_cause_t;

endpackage

// ==== rtl/rwm_watchdog.sv ====
`timescale 1ns/1ps
module rwm_watchdog #(
  parameter int DIV_LOG2 = rwm_pkg::WDOG_DIV_LOG2
) (
  input  wire logic       clk,          // system clock
  input  wire logic       rst_n,        // async reset, active low
  input  wire logic       clear,        // hold counter and arm flag cleared
  input  wire logic       busTick,      // one pulse per bus clock cycle
  input  wire logic [1:0] rate,         // timeout rate select
  input  wire logic       serviceWrite, // service register write pulse
  input  wire logic [7:0] serviceData,  // byte written to service register
  output logic            timeout       // one-cycle timeout pulse
);

  localparam int CNT_W = DIV_LOG2 + 6;

  logic [CNT_W-1:0] count;
  logic             armed;
  logic [CNT_W-1:0] limit;
  logic             isArm;
  logic             isClear;
  logic             atLimit;

  // factor 1, 4, 16, 64 is a shift of 0, 2, 4, 6
  assign limit   = (CNT_W'(1) << (DIV_LOG2 + 2 * int'(rate))) - CNT_W'(1);
  assign isArm   = serviceWrite && (serviceData == rwm_pkg::SERVICE_ARM);
  assign isClear = serviceWrite && (serviceData == rwm_pkg::SERVICE_CLEAR) && armed;
  assign atLimit = busTick && (count == limit);

  // counts bus clock ticks only, so it freezes whenever the bus clock stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear || isClear || atLimit) begin
      count <= '0;
    end else if (busTick) begin
      count <= count + CNT_W'(1);
    end
  end

  // arm survives unrelated writes; any other value written leaves it as is
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (clear || isClear) begin
      armed <= 1'b0;
    end else if (isArm) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= atLimit && !clear && !isClear;
    end
  end

endmodule

// ==== rtl/rwm_clock_monitor.sv ====
`timescale 1ns/1ps
module rwm_clock_monitor #(
  parameter int TIMEOUT_CYC = rwm_pkg::CM_TIMEOUT_CYC
) (
  input  wire logic clk,      // reference clock, independent of the bus clock
  input  wire logic rst_n,    // async reset, active low
  input  wire logic enable,   // clock monitor enable
  input  wire logic busTick,  // one pulse per bus clock cycle
  output logic      fail      // one-cycle failure pulse
);

  localparam int W = $clog2(TIMEOUT_CYC + 1);

  logic [W-1:0] gap;
  logic         tripped;

  assign tripped = (gap == W'(TIMEOUT_CYC - 1)) && !busTick;

  // measures the gap between bus ticks on the reference clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
    end else if (!enable || busTick || tripped) begin
      gap <= '0;
    end else begin
      gap <= gap + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail <= 1'b0;
    end else begin
      fail <= enable && tripped;
    end
  end

endmodule

// ==== rtl/rwm_reset_ctrl.sv ====
// How it works
// - four sources; power-on and pin share a vector, watchdog and monitor own ones
// - after power-up hold reset for 4064 clock cycles
// - if the pin is still low after that delay, wait until it rises
// - any reset sensed while running drives the pin low four cycles, then releases it
// - sample the pin two cycles after release; low means external cause
// - watchdog disable configuration bit is captured only during reset
// - disable bit 0 enables watchdog resets, 1 disables them
// - special modes start with watchdog resets inhibited by a test bit
// - timeout is 2^15 bus cycles times 1, 4, 16 or 64
// - reset clears the rate field, selecting the shortest timeout
// - normal mode allows one rate write within 64 cycles of reset
// - write arm value then clear value to restart the watchdog
// - other activity may come between the arm and clear writes
// - an enabled watchdog reaching its timeout starts a system reset
// - the watchdog stops counting while the bus clock is stopped
// - enabled clock monitor resets when no clock edge comes in its delay
// - below 10 kHz always flagged, 200 kHz and above never flagged
// - stopping clocks with the monitor enabled causes a reset
// - monitor enable is read-write any time and cleared by reset
// - irq sensitivity bit selects level (0) or edge-only (1)
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module rwm_reset_ctrl #(
  parameter int WDOG_DIV_LOG2  = rwm_pkg::WDOG_DIV_LOG2,
  parameter int CM_TIMEOUT_CYC = rwm_pkg::CM_TIMEOUT_CYC
) (
  input  wire logic        clk,                // system clock, 100 MHz
  input  wire logic        rst_n,              // power-on reset, async, active low
  // ahb-lite slave
  input  wire logic        hsel,               // slave select
  input  wire logic [31:0] haddr,              // address
  input  wire logic [1:0]  htrans,             // transfer type
  input  wire logic        hwrite,             // write strobe
  input  wire logic [2:0]  hsize,              // transfer size
  input  wire logic [31:0] hwdata,             // write data
  input  wire logic        hready,             // bus ready
  output logic [31:0]      hrdata,             // read data
  output logic             hreadyout,          // slave ready
  output logic             hresp,              // response, always okay
  // reset pin, open drain
  input  wire logic        resetPinIn,         // reset pin level
  output logic             resetPinOut,        // reset pin drive value
  output logic             resetPinOe,         // reset pin drive enable
  // system side
  input  wire logic        busTick,            // one pulse per bus clock cycle
  input  wire logic        specialMode,        // special test or bootstrap mode
  input  wire logic        watchdogDisableCfg, // non-volatile watchdog disable
  output logic             systemReset,        // core held in reset
  output rwm_pkg::rwm_cause_t resetCause,      // selects the reset vector
  output logic             irqEdgeSelect,      // irq pin edge-only sensitivity
  output logic             watchdogActive      // watchdog resets enabled
);

  // ----------------------------------------------------------------------
  // reset sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_PIN_HOLD,
    ST_RUN,
    ST_DRIVE,
    ST_SETTLE
  } rwm_seq_t;

  rwm_seq_t                              state;
  rwm_seq_t                              next_state;
  logic [rwm_pkg::SEQ_CNT_W-1:0]         seqCount;
  logic [rwm_pkg::SEQ_CNT_W-1:0]         next_seqCount;
  rwm_pkg::rwm_cause_t                   next_resetCause;

  logic                                  watchdogTimeout;
  logic                                  clockFail;
  logic                                  watchdogOff;
  logic                                  disableResets;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  rwm_pkg::rwm_options_t                 options;
  logic                                  rateWritten;
  logic [6:0]                            sinceReset;
  logic                                  phaseWrite;
  logic [7:0]                            phaseAddr;
  logic                                  addrValid;
  logic                                  writeOptions;
  logic                                  writeService;
  logic                                  writeTest;
  logic                                  rateWindowOpen;
  logic                                  rateWritable;
  logic [31:0]                           readValue;
  logic [31:0]                           statusWord;
  rwm_pkg::rwm_options_t                 wrOptions;

  assign addrValid = hsel && hready && htrans[1];
  assign wrOptions = rwm_pkg::rwm_options_t'(hwdata[7:0]);

  assign writeOptions = phaseWrite && (phaseAddr == rwm_pkg::OFS_OPTIONS);
  assign writeService = phaseWrite && (phaseAddr == rwm_pkg::OFS_SERVICE);
  assign writeTest    = phaseWrite && (phaseAddr == rwm_pkg::OFS_TEST);

  assign rateWindowOpen = (sinceReset < 7'(rwm_pkg::RATE_WINDOW_CYC)) && !rateWritten;
  assign rateWritable   = specialMode || rateWindowOpen;

  assign statusWord = {25'h0000000, watchdogActive, watchdogOff, resetPinIn,
                       disableResets, 1'b0, resetCause};

  assign readValue =
      (haddr[7:0] == rwm_pkg::OFS_OPTIONS) ? {24'h000000, options} :
      (haddr[7:0] == rwm_pkg::OFS_TEST)    ? {31'h00000000, disableResets} :
      (haddr[7:0] == rwm_pkg::OFS_STATUS)  ? statusWord :
                                             32'h00000000;

  // zero wait state slave; every access completes with okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------------
  // ahb address phase capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseWrite <= 1'b0;
      phaseAddr  <= 8'h00;
    end else if (hready) begin
      phaseWrite <= addrValid && hwrite;
      phaseAddr  <= haddr[7:0];
    end
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrValid && !hwrite) begin
      hrdata <= readValue;
    end
  end

  // ----------------------------------------------------------------------
  // system options register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      options <= rwm_pkg::OPTIONS_RESET;
    end else if (systemReset) begin
      options <= rwm_pkg::OPTIONS_RESET;
    end else if (writeOptions) begin
      options.adpu               <= wrOptions.adpu;
      options.csel               <= wrOptions.csel;
      options.irqEdgeSelect      <= wrOptions.irqEdgeSelect;
      options.dly                <= wrOptions.dly;
      options.clockMonitorEnable <= wrOptions.clockMonitorEnable;
      if (rateWritable) begin
        options.watchdogRate <= wrOptions.watchdogRate;
      end
    end
  end

  // the once-only window counts from the release of any system reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceReset  <= 7'h00;
      rateWritten <= 1'b0;
    end else if (systemReset) begin
      sinceReset  <= 7'h00;
      rateWritten <= 1'b0;
    end else begin
      if (sinceReset < 7'(rwm_pkg::RATE_WINDOW_CYC)) begin
        sinceReset <= sinceReset + 7'h01;
      end
      if (writeOptions && rateWindowOpen && !specialMode) begin
        rateWritten <= 1'b1;
      end
    end
  end

  assign irqEdgeSelect = options.irqEdgeSelect;

  // ----------------------------------------------------------------------
  // watchdog enable: configuration sampled only while in reset
  // ----------------------------------------------------------------------
  // test bit loads the mode each reset, so special modes start inhibited
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdogOff   <= 1'b1;
      disableResets <= 1'b1;
    end else if (systemReset) begin
      watchdogOff   <= watchdogDisableCfg;
      disableResets <= specialMode;
    end else if (writeTest && specialMode) begin
      disableResets <= hwdata[rwm_pkg::TEST_RESET_DISABLE_BIT];
    end
  end

  assign watchdogActive = !watchdogOff && !disableResets;

  // ----------------------------------------------------------------------
  // watchdog and clock monitor
  // ----------------------------------------------------------------------
  rwm_watchdog #(
    .DIV_LOG2     (WDOG_DIV_LOG2)
  ) u_watchdog (
    .clk          (clk),
    .rst_n        (rst_n),
    .clear        (systemReset || !watchdogActive),
    .busTick      (busTick),
    .rate         (options.watchdogRate),
    .serviceWrite (writeService),
    .serviceData  (hwdata[7:0]),
    .timeout      (watchdogTimeout)
  );

  rwm_clock_monitor #(
    .TIMEOUT_CYC  (CM_TIMEOUT_CYC)
  ) u_clock_monitor (
    .clk          (clk),
    .rst_n        (rst_n),
    .enable       (options.clockMonitorEnable && !systemReset),
    .busTick      (busTick),
    .fail         (clockFail)
  );

  // ----------------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_seqCount   = seqCount;
    next_resetCause = resetCause;
    unique case (state)
      ST_POWER_UP: begin
        next_seqCount = seqCount + 12'h001;
        if (seqCount == 12'(rwm_pkg::POR_DELAY_CYC - 1)) begin
          next_seqCount = '0;
          next_state    = resetPinIn ? ST_RUN : ST_PIN_HOLD;
        end
      end
      ST_PIN_HOLD: begin
        if (resetPinIn) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // monitor outranks watchdog when both fire together
        if (clockFail) begin
          next_resetCause = rwm_pkg::CAUSE_CLOCK_MON;
          next_state      = ST_DRIVE;
        end else if (watchdogTimeout) begin
          next_resetCause = rwm_pkg::CAUSE_WATCHDOG;
          next_state      = ST_DRIVE;
        end else if (!resetPinIn) begin
          next_resetCause = rwm_pkg::CAUSE_POWER_PIN;
          next_state      = ST_DRIVE;
        end
        next_seqCount = '0;
      end
      ST_DRIVE: begin
        next_seqCount = seqCount + 12'h001;
        if (seqCount == 12'(rwm_pkg::PIN_DRIVE_CYC - 1)) begin
          next_seqCount = '0;
          next_state    = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_seqCount = seqCount + 12'h001;
        if (seqCount == 12'(rwm_pkg::PIN_SAMPLE_CYC - 1)) begin
          next_seqCount = '0;
          if (!resetPinIn) begin
            // an external driver holds the pin: external reset wins
            next_resetCause = rwm_pkg::CAUSE_POWER_PIN;
            next_state      = ST_PIN_HOLD;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      default: begin
        next_state    = ST_POWER_UP;
        next_seqCount = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_POWER_UP;
      seqCount   <= '0;
      resetCause <= rwm_pkg::CAUSE_POWER_PIN;
    end else begin
      state      <= next_state;
      seqCount   <= next_seqCount;
      resetCause <= next_resetCause;
    end
  end

  // open drain: only ever pulls low
  assign resetPinOut = 1'b0;
  assign resetPinOe  = (state == ST_DRIVE);
  assign systemReset = (state != ST_RUN);

endmodule

// ==== tb/rwm_checker.sv ====
`timescale 1ns/1ps
module rwm_checker #(
  parameter int CM_TIMEOUT_CYC = rwm_pkg::CM_TIMEOUT_CYC
) (
  input wire logic                clk,                // system clock
  input wire logic                rst_n,              // async reset, active low
  input wire logic                resetPinIn,         // reset pin level
  input wire logic                resetPinOut,        // reset pin drive value
  input wire logic                resetPinOe,         // reset pin drive enable
  input wire logic                busTick,            // bus clock pulse
  input wire logic                specialMode,        // special mode
  input wire logic                watchdogDisableCfg, // watchdog disable bit
  input wire logic                systemReset,        // core held in reset
  input wire rwm_pkg::rwm_cause_t resetCause,         // reset vector select
  input wire logic                watchdogActive      // watchdog resets enabled
);
  logic [12:0] porCnt;
  logic [15:0] tickAge;
  logic        cfgLatch;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // counters saturate so a long run never wraps into a false antecedent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      porCnt   <= 13'h0;
      tickAge  <= 16'h0;
      cfgLatch <= 1'b1;
    end else begin
      if (porCnt != 13'h1fff) porCnt <= porCnt + 13'h1;
      if (busTick) tickAge <= 16'h0;
      else if (tickAge != 16'hffff) tickAge <= tickAge + 16'h1;
      if (systemReset) cfgLatch <= watchdogDisableCfg;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pin_drive_four: assert property ($rose(resetPinOe) |-> resetPinOe[*4] ##1 !resetPinOe)
    else $error("reset pin drive is not four cycles");
  a_drive_in_reset: assert property (resetPinOe |-> systemReset && !resetPinOut)
    else $error("reset pin driven outside reset");
  a_sample_internal: assert property ($fell(resetPinOe) ##1 resetPinIn |=> !systemReset)
    else $error("internal reset not ended after high sample");
  a_sample_external: assert property ($fell(resetPinOe) ##1 !resetPinIn |=>
    systemReset && resetCause == rwm_pkg::CAUSE_POWER_PIN)
    else $error("low sample not taken as external reset");
  a_por_hold: assert property (porCnt < 13'hfe0 |-> systemReset)
    else $error("power-on hold ended early");
  a_pin_holds_reset: assert property (!resetPinIn |=> systemReset)
    else $error("core runs while reset pin is low");
  a_cause_stable: assert property ($changed(resetCause) |-> systemReset)
    else $error("reset cause changed while running");
  a_monitor_gap: assert property ($rose(resetPinOe) && $past(resetPinIn)
    && !$past(watchdogActive) |-> int'(tickAge) >= CM_TIMEOUT_CYC / 2)
    else $error("clock monitor fired with the clock running");
  a_cfg_latched: assert property (!systemReset && !$past(systemReset) && watchdogActive
    |-> !cfgLatch)
    else $error("watchdog active against latched disable bit");
  a_special_inhibit: assert property (specialMode && $fell(systemReset) |=> !watchdogActive)
    else $error("watchdog not inhibited in special mode");
endmodule

bind rwm_reset_ctrl rwm_checker #(.CM_TIMEOUT_CYC(CM_TIMEOUT_CYC)) uChecker (
  .clk(clk), .rst_n(rst_n), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
  .resetPinOe(resetPinOe), .busTick(busTick), .specialMode(specialMode),
  .watchdogDisableCfg(watchdogDisableCfg), .systemReset(systemReset),
  .resetCause(resetCause), .watchdogActive(watchdogActive));

// ==== tb/rwm_ext_reset.sv ====
`timescale 1ns/1ps
module rwm_ext_reset (
  input wire logic       clk,      // system clock
  input wire logic       holdLow,  // request to pull the pin low
  input wire logic [3:0] lag,      // extra low cycles after the request ends
  input wire logic       devOe,    // device drive enable
  input wire logic       devOut,   // device drive value
  output logic           pinLevel  // resolved pin level
);
  logic [3:0] lagCnt = 4'h0;

  // a slow release models a sluggish external supervisor
  always @(posedge clk) begin
    if (holdLow) lagCnt <= lag;
    else if (lagCnt != 4'h0) lagCnt <= lagCnt - 4'h1;
  end

  // open drain with pull-up: low if either party pulls
  assign pinLevel = !(devOe && !devOut) && !holdLow && lagCnt == 4'h0;
endmodule

// ==== tb/reset_watchdog_clock_monitor_test.sv ====
`timescale 1ns/1ps
module reset_watchdog_clock_monitor_test;
  localparam int WDOG_LOG2 = 4;
  localparam int CM_CYC    = 50;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, resetPinIn, resetPinOut, resetPinOe;
  logic        busTick = 1'b0, ticksOn = 1'b1, specialMode = 1'b0, cfgOff = 1'b0;
  logic        holdLow = 1'b1, systemReset, irqEdgeSelect, watchdogActive;
  logic [3:0]  lag = 4'h0;
  logic [31:0] rd;
  rwm_pkg::rwm_cause_t resetCause;
  int          badCount = 0, nCompared = 0, seed = 32'hdde4, gap = 0, tickTotal = 0, t0, d;

  rwm_reset_ctrl #(.WDOG_DIV_LOG2(WDOG_LOG2), .CM_TIMEOUT_CYC(CM_CYC)) uut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .busTick(busTick),
    .specialMode(specialMode), .watchdogDisableCfg(cfgOff), .systemReset(systemReset),
    .resetCause(resetCause), .irqEdgeSelect(irqEdgeSelect), .watchdogActive(watchdogActive));
  rwm_ext_reset uExt (.clk(clk), .holdLow(holdLow), .lag(lag), .devOe(resetPinOe),
    .devOut(resetPinOut), .pinLevel(resetPinIn));

  // ------------------------------------------------------------------
  // clock and bus clock ticks
  // ------------------------------------------------------------------
  initial forever #5 clk = ~clk;

  // irregular tick spacing keeps the watchdog count honest
  always @(posedge clk) begin
    if (busTick) tickTotal = tickTotal + 1;
    if (gap == 0) begin
      busTick <= ticksOn;
      gap = 1 + ($random(seed) & 3);
    end else begin
      busTick <= 1'b0;
      gap = gap - 1;
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut;
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic busAccess(input logic wr, input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    busAccess(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  // sel 0 waits on the pin drive, 1 on the core reset
  task automatic waitFor(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? resetPinOe : systemReset) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      badCount++;
      closeOut();
    end
  endtask

  task automatic pinReset(input logic [3:0] l);
    @(posedge clk);
    lag     <= l;
    holdLow <= 1'b1;
    repeat (20) @(posedge clk);
    check(32'(systemReset), 32'h1);
    holdLow <= 1'b0;
    waitFor(1, 1'b0, 60);
    check(32'(resetCause), 32'(rwm_pkg::CAUSE_POWER_PIN));
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    #(60000 * 10);
    badCount++;
    closeOut();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4100) @(posedge clk);
    check(32'(systemReset), 32'h1);
    holdLow <= 1'b0;
    waitFor(1, 1'b0, 60);
    check(32'(resetCause), 32'(rwm_pkg::CAUSE_POWER_PIN));
    for (int r = 0; r < 4; r++) begin
      logic [7:0] v;
      v = {2'b00, r[0], 3'b000, r[1:0]};
      rdChk(rwm_pkg::OFS_OPTIONS, 8'h10);
      busAccess(1'b1, rwm_pkg::OFS_OPTIONS, v);
      busAccess(1'b1, rwm_pkg::OFS_OPTIONS, v ^ 8'h03);
      rdChk(rwm_pkg::OFS_OPTIONS, v);
      check(32'(irqEdgeSelect), 32'(r & 1));
      busAccess(1'b1, rwm_pkg::OFS_SERVICE, rwm_pkg::SERVICE_ARM);
      rdChk(rwm_pkg::OFS_SERVICE, 8'h00);
      busAccess(1'b1, rwm_pkg::OFS_SERVICE, rwm_pkg::SERVICE_CLEAR);
      t0 = tickTotal;
      busAccess(1'b1, rwm_pkg::OFS_SERVICE, rwm_pkg::SERVICE_CLEAR);
      rdChk(8'h20, 8'h00);
      if (r == 3) begin
        cfgOff <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(watchdogActive), 32'h1);
      end
      waitFor(0, 1'b1, 6000);
      d = tickTotal - t0 - (1 << (WDOG_LOG2 + 2 * r));
      check(32'(d >= -3 && d <= 3), 32'h1);
      waitFor(1, 1'b0, 60);
      check(32'(resetCause), 32'(rwm_pkg::CAUSE_WATCHDOG));
    end
    repeat (3) @(posedge clk);
    check(32'(watchdogActive), 32'h0);
    repeat (70) @(posedge clk);
    busAccess(1'b1, rwm_pkg::OFS_OPTIONS, 8'h03);
    rdChk(rwm_pkg::OFS_OPTIONS, 8'h00);
    ticksOn <= 1'b0;
    repeat (200) @(posedge clk);
    check(32'(systemReset), 32'h0);
    ticksOn <= 1'b1;
    busAccess(1'b1, rwm_pkg::OFS_OPTIONS, 8'h18);
    repeat (200) @(posedge clk);
    check(32'(systemReset), 32'h0);
    rdChk(rwm_pkg::OFS_OPTIONS, 8'h18);
    ticksOn <= 1'b0;
    waitFor(0, 1'b1, 4 * CM_CYC);
    ticksOn <= 1'b1;
    waitFor(1, 1'b0, 60);
    check(32'(resetCause), 32'(rwm_pkg::CAUSE_CLOCK_MON));
    rdChk(rwm_pkg::OFS_STATUS, 8'h31);
    pinReset(4'h5);
    specialMode <= 1'b1;
    cfgOff      <= 1'b0;
    pinReset(4'h0);
    repeat (3) @(posedge clk);
    check(32'(watchdogActive), 32'h0);
    rdChk(rwm_pkg::OFS_TEST, 8'h01);
    busAccess(1'b1, rwm_pkg::OFS_TEST, 8'h00);
    repeat (2) @(posedge clk);
    check(32'(watchdogActive), 32'h1);
    // inhibit again so the shortest timeout cannot fire during the rate test
    busAccess(1'b1, rwm_pkg::OFS_TEST, 8'h01);
    rdChk(rwm_pkg::OFS_TEST, 8'h01);
    repeat (70) @(posedge clk);
    busAccess(1'b1, rwm_pkg::OFS_OPTIONS, 8'h02);
    rdChk(rwm_pkg::OFS_OPTIONS, 8'h02);
    closeOut();
  end
endmodule
